//--- inc/rdf_pkg.sv
// constants, register map and field layouts of the recorder data block framer
package rdf_pkg;
    // ************************************************************
    // block geometry
    // ************************************************************
    localparam int          BLOCK_WORDS    = 2048;
    localparam int          SESSION_WORDS  = 8;
    localparam int          CHAN_HDR_WORDS = 5;
    localparam int          WORD_BITS      = 24;
    localparam logic [23:0] SYNC_LOW       = 24'h36e19c;
    localparam logic [4:0]  SYNC_HIGH      = 5'h09;
    localparam logic [23:0] FILL_WORD      = 24'hffffff;
    localparam logic [10:0] MAX_WORD_COUNT = 11'h7f8;

    // ************************************************************
    // session word 6 / 7 field positions
    // ************************************************************
    localparam int ORIGIN_POS    = 23;
    localparam int CHCOUNT_LSB   = 19;
    localparam int SPARE_PAIR_LSB = 17;
    localparam int START_SEC_LSB = 0;
    localparam int USER_LSB      = 16;
    localparam int SPARE_TEN_LSB = 6;

    // ************************************************************
    // timing
    // ************************************************************
    localparam longint SECOND_NS     = 1000000000;
    localparam longint CLK_PERIOD_NS = 20;
    localparam int     SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] CTRL_ADDR      = 8'h00;
    localparam logic [7:0] MCLK_ADDR      = 8'h04;
    localparam logic [7:0] DIVISOR_ADDR   = 8'h08;
    localparam logic [7:0] CHCOUNT_ADDR   = 8'h0c;
    localparam logic [7:0] START_SEC_ADDR = 8'h10;
    localparam logic [7:0] USER_ADDR      = 8'h14;
    localparam logic [7:0] REVISION_ADDR  = 8'h18;
    localparam logic [7:0] DATE_ADDR      = 8'h1c;
    localparam logic [7:0] TIME_ADDR      = 8'h20;
    localparam logic [7:0] BLKCNT_ADDR    = 8'h24;
    localparam logic [7:0] STATUS_ADDR    = 8'h28;
    localparam logic [7:0] CHCFG_BASE     = 8'h40;

    // control bits
    localparam int CTRL_RECORD = 0;
    localparam int CTRL_START  = 1;
    localparam int CTRL_ORIGIN = 2;

    // reset values
    localparam logic [5:0] REVISION_RESET = 6'h01;

    typedef enum logic [2:0] {
        RDF_IDLE, RDF_SESSION, RDF_CH_SETUP, RDF_CH_HDR, RDF_CH_DATA, RDF_FILL
    } rdf_state_e;
endpackage

//--- hw/rdf_framer.sv
// recorder data block framer: session header, channel packets, sample packing, fill
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - every block is 2048 words of 24 bits, opening with eight session words.
// - session word 0 holds low 24 sync bits, constant 36e19c.
// - session word 1 bits 23..19 hold sync top bits 01001.
// - session word 1 bits 18..0 hold master clock rate in 250 Hz steps.
// - session word 2 counts blocks; cleared at session start, wraps on overflow.
// - session word 3 carries BCD date, refreshed once a second while recording.
// - session word 4 carries BCD time of day, refreshed once a second while recording.
// - session word 5 holds the block marker divisor.
// - session word 6 bit 23 is one for an internal master clock.
// - session word 6 bits 22..19 hold active channels minus one.
// - the two spare bits of session word 6 are always zero.
// - session word 6 bits 16..0 hold session start seconds since midnight.
// - session word 7 bits 23..16 hold a user value writable any time.
// - session word 7 bits 15..6 are always zero.
// - session word 7 bits 5..0 hold the format revision.
// - each active channel has a packet with five header words, first at word 8.
// - packets go out in ascending logical channel order.
// - channel header word 0 bits 23..20 hold the physical slot.
// - channel header word 0 bits 19..16 hold the sample width code.
// - channel header word 0 bits 15..5 hold the full word count, 0..2040.
// - a channel that does not fit still reports its full intended count.
// - channel header word 0 bits 4..0 hold the leftover sample status.
// - after the last packet the block is padded with all-ones words.
// - samples pack from the msb down, a sample that does not fit splits.
module rdf_framer #(
    parameter int NUM_CH      = 16,
    parameter int TICK_CYCLES = rdf_pkg::SECOND_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    input  wire logic        block_go_i,
    input  wire logic        sample_valid_i,
    input  wire logic [23:0] sample_i,
    output logic             sample_ready_o,
    output logic      [3:0]  sample_chan_o,
    output logic      [23:0] word_o,
    output logic             word_valid_o,
    output logic             block_start_o
);
    import rdf_pkg::*;

    // ************************************************************
    // software registers
    // ************************************************************
    logic        record_en;
    logic        master_clock_origin_flag;
    logic [18:0] master_clock_rate;
    logic [23:0] block_marker_divisor;
    logic [3:0]  active_m1;
    logic [16:0] session_start_seconds;
    logic [7:0]  user_value;
    logic [5:0]  format_revision;
    logic [23:0] date_shadow;
    logic [23:0] time_shadow;
    logic [23:0] date_bcd_field;
    logic [23:0] time_of_day_bcd_field;
    logic [23:0] block_sequence_counter;
    logic [31:0] chan_cfg [NUM_CH];
    logic        session_start;

    rdf_state_e  state;
    logic [10:0] pos;
    logic [2:0]  widx;
    logic [3:0]  ch;
    logic        block_end;

    assign session_start = wr_i && addr_i == CTRL_ADDR && wr_data_i[CTRL_START];

    // control and session fields; the user value may change mid-block
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            record_en                <= 1'b0;
            master_clock_origin_flag <= 1'b0;
            master_clock_rate        <= 19'h0;
            block_marker_divisor     <= 24'h0;
            active_m1                <= 4'h0;
            session_start_seconds    <= 17'h0;
            user_value               <= 8'h0;
            format_revision          <= REVISION_RESET;
            date_shadow              <= 24'h0;
            time_shadow              <= 24'h0;
        end else if (wr_i) begin
            case (addr_i)
                CTRL_ADDR: begin
                    record_en                <= wr_data_i[CTRL_RECORD];
                    master_clock_origin_flag <= wr_data_i[CTRL_ORIGIN];
                end
                MCLK_ADDR:      master_clock_rate     <= wr_data_i[18:0];
                DIVISOR_ADDR:   block_marker_divisor  <= wr_data_i[23:0];
                CHCOUNT_ADDR:   active_m1             <= wr_data_i[3:0];
                START_SEC_ADDR: session_start_seconds <= wr_data_i[16:0];
                USER_ADDR:      user_value            <= wr_data_i[7:0];
                REVISION_ADDR:  format_revision       <= wr_data_i[5:0];
                DATE_ADDR:      date_shadow           <= wr_data_i[23:0];
                TIME_ADDR:      time_shadow           <= wr_data_i[23:0];
                default: ;
            endcase
        end
    end

    // per-channel config: [31:28] slot, [27:24] width code, [15:0] intended samples
    for (genvar g = 0; g < NUM_CH; g++) begin : g_cfg
        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                chan_cfg[g] <= 32'h0;
            end else if (wr_i && addr_i == CHCFG_BASE + 8'(4 * g)) begin
                chan_cfg[g] <= wr_data_i;
            end
        end
    end

    // read port: data valid from the cycle after the strobe until the next read, unmapped reads zero
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_data_o <= 32'h0;
        end else if (rd_i) begin
            rd_data_o <= 32'h0;
            case (addr_i)
                CTRL_ADDR:      rd_data_o <= {29'h0, master_clock_origin_flag, 1'b0, record_en};
                MCLK_ADDR:      rd_data_o <= {13'h0, master_clock_rate};
                DIVISOR_ADDR:   rd_data_o <= {8'h0, block_marker_divisor};
                CHCOUNT_ADDR:   rd_data_o <= {28'h0, active_m1};
                START_SEC_ADDR: rd_data_o <= {15'h0, session_start_seconds};
                USER_ADDR:      rd_data_o <= {24'h0, user_value};
                REVISION_ADDR:  rd_data_o <= {26'h0, format_revision};
                DATE_ADDR:      rd_data_o <= {8'h0, date_shadow};
                TIME_ADDR:      rd_data_o <= {8'h0, time_shadow};
                BLKCNT_ADDR:    rd_data_o <= {8'h0, block_sequence_counter};
                STATUS_ADDR:    rd_data_o <= {27'h0, ch, state != RDF_IDLE}; // busy in bit 0, channel above it
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (addr_i == CHCFG_BASE + 8'(4 * i)) begin
                            rd_data_o <= chan_cfg[i];
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // one-second refresh of date and time
    // ************************************************************
    logic [31:0] tick_cnt;
    logic        sec_tick;

    // free running divider; the pulse is a clock enable, not a clock
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end
    assign sec_tick = tick_cnt == 32'(TICK_CYCLES - 1);

    // header copies only move on the tick or a session start, so a block never sees a half-written value
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            date_bcd_field        <= 24'h0;
            time_of_day_bcd_field <= 24'h0;
        end else if (session_start || (sec_tick && record_en)) begin
            date_bcd_field        <= date_shadow;
            time_of_day_bcd_field <= time_shadow;
        end
    end

    // block numbering restarts with each session, otherwise wraps freely
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || session_start) begin
            block_sequence_counter <= 24'h0;
        end else if (block_end) begin
            block_sequence_counter <= block_sequence_counter + 24'h1;
        end
    end

    // ************************************************************
    // channel geometry
    // ************************************************************
    logic [3:0]  cur_slot;
    logic [3:0]  cur_code;
    logic [4:0]  cur_w;
    logic [10:0] cur_wc;
    logic [4:0]  cur_rem;
    logic [4:0]  cur_pws;
    logic [15:0] samples_left;
    logic [4:0]  cfg_w;
    logic [20:0] cfg_bits;
    logic [20:0] cfg_words;
    logic [20:0] cfg_rem;
    logic [4:0]  cfg_unused;

    // width code to bits: 0..7 give 1..8, 8..15 give 10..24 in steps of two
    always_comb begin
        logic [3:0] code;
        code = chan_cfg[ch][27:24];
        if (code < 4'h8) begin
            cfg_w = 5'(code) + 5'h1;
        end else begin
            cfg_w = 5'({code - 4'h7, 1'b0}) + 5'h8;
        end
        cfg_bits   = 21'(chan_cfg[ch][15:0]) * 21'(cfg_w);
        cfg_words  = cfg_bits / 21'(WORD_BITS);
        cfg_rem    = cfg_bits - cfg_words * 21'(WORD_BITS);
        cfg_unused = 5'(WORD_BITS) - cfg_rem[4:0];
    end

    // ************************************************************
    // sample packer
    // ************************************************************
    logic [47:0] acc;
    logic [5:0]  fill;
    logic        pw_phase;
    logic        pack_emit;
    logic        take;
    logic [23:0] pack_word;
    logic [5:0]  shamt;

    // the partial word leads, so it holds the oldest samples of the channel
    assign pack_emit = pw_phase ? fill >= 6'(cur_rem) : fill >= 6'(WORD_BITS);
    assign take      = sample_ready_o && sample_valid_i;
    assign shamt     = 6'd48 - fill - 6'(cur_w);
    assign pack_word = pw_phase ? (acc[47:24] & ~(24'hffffff >> cur_rem)) : acc[47:24];

    // bits fill from the msb down; a sample crossing a word edge is split there
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || state == RDF_CH_SETUP) begin
            acc  <= 48'h0;
            fill <= 6'h0;
        end else if (state == RDF_CH_DATA && pack_emit) begin
            acc  <= pw_phase ? acc << cur_rem : acc << WORD_BITS;
            fill <= pw_phase ? fill - 6'(cur_rem) : fill - 6'(WORD_BITS);
        end else if (take) begin
            acc  <= acc | ((48'(sample_i) & ~(48'hffffffffffff << cur_w)) << shamt);
            fill <= fill + 6'(cur_w);
        end
    end

    // ready is raised at most every other cycle so the flop output always reflects current fill
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sample_ready_o <= 1'b0;
        end else begin
            sample_ready_o <= state == RDF_CH_DATA && !sample_ready_o && !pack_emit
                              && samples_left != 16'h0 && pos != 11'(BLOCK_WORDS - 1);
        end
    end

    // ************************************************************
    // block sequencer
    // ************************************************************
    logic        emit;
    logic [23:0] next_word;
    logic        last_word;

    // one word per emitting cycle, in fixed block order
    always_comb begin
        emit      = 1'b0;
        next_word = FILL_WORD;
        case (state)
            RDF_SESSION: begin
                emit = 1'b1;
                case (widx)
                    3'd0: next_word = SYNC_LOW;
                    3'd1: next_word = {SYNC_HIGH, master_clock_rate};
                    3'd2: next_word = block_sequence_counter;
                    3'd3: next_word = date_bcd_field;
                    3'd4: next_word = time_of_day_bcd_field;
                    3'd5: next_word = block_marker_divisor;
                    3'd6: next_word = {master_clock_origin_flag, active_m1, 2'b00, session_start_seconds};
                    default: next_word = {user_value, 10'h0, format_revision};
                endcase
            end
            RDF_CH_HDR: begin
                emit      = 1'b1;
                next_word = (widx == 3'd0) ? {cur_slot, cur_code, cur_wc, cur_pws} : 24'h0;
            end
            RDF_CH_DATA: begin
                emit      = pack_emit;
                next_word = pack_word;
            end
            RDF_FILL: begin
                emit      = 1'b1;
                next_word = FILL_WORD;
            end
            default: ;
        endcase
    end

    assign last_word = emit && pos == 11'(BLOCK_WORDS - 1);
    assign block_end = last_word;

    // stream outputs come straight from flops
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            word_o        <= 24'h0;
            word_valid_o  <= 1'b0;
            block_start_o <= 1'b0;
            sample_chan_o <= 4'h0;
        end else begin
            word_o        <= next_word;
            word_valid_o  <= emit;
            block_start_o <= emit && pos == 11'h0;
            sample_chan_o <= ch;
        end
    end

    // walks session words, channel packets in ascending order, then fill
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state        <= RDF_IDLE;
            pos          <= 11'h0;
            widx         <= 3'h0;
            ch           <= 4'h0;
            pw_phase     <= 1'b0;
            samples_left <= 16'h0;
            cur_slot     <= 4'h0;
            cur_code     <= 4'h0;
            cur_w        <= 5'h1;
            cur_wc       <= 11'h0;
            cur_rem      <= 5'h0;
            cur_pws      <= 5'h0;
        end else begin
            if (emit) begin
                pos <= pos + 11'h1;
            end
            if (take) begin
                samples_left <= samples_left - 16'h1;
            end
            if (last_word) begin
                state <= RDF_IDLE;
                pos   <= 11'h0;
            end else begin
                case (state)
                    RDF_IDLE: begin
                        if (block_go_i && record_en) begin
                            state <= RDF_SESSION;
                            widx  <= 3'h0;
                        end
                    end
                    RDF_SESSION: begin
                        widx <= widx + 3'h1;
                        if (widx == 3'(SESSION_WORDS - 1)) begin
                            ch    <= 4'h0;
                            state <= RDF_CH_SETUP;
                        end
                    end
                    RDF_CH_SETUP: begin
                        cur_slot     <= chan_cfg[ch][31:28];
                        cur_code     <= chan_cfg[ch][27:24];
                        cur_w        <= cfg_w;
                        cur_wc       <= cfg_words[10:0];
                        cur_rem      <= cfg_rem[4:0];
                        cur_pws      <= (cfg_rem[4:0] < cfg_w) ? 5'h0
                                        : 5'((6'(cfg_unused) + 6'(cfg_w) - 6'h1) / 6'(cfg_w));
                        samples_left <= chan_cfg[ch][15:0];
                        pw_phase     <= 1'b1;
                        widx         <= 3'h0;
                        state        <= RDF_CH_HDR;
                    end
                    RDF_CH_HDR: begin
                        widx <= widx + 3'h1;
                        if (widx == 3'(CHAN_HDR_WORDS - 2)) begin
                            state <= RDF_CH_DATA; // fifth header word is the partial word
                        end
                    end
                    RDF_CH_DATA: begin
                        if (pack_emit) begin
                            pw_phase <= 1'b0;
                        end else if (samples_left == 16'h0 && !pw_phase && !sample_ready_o) begin
                            if (ch == active_m1) begin
                                state <= RDF_FILL;
                            end else begin
                                ch    <= ch + 4'h1;
                                state <= RDF_CH_SETUP;
                            end
                        end
                    end
                    RDF_FILL: ;
                    default: state <= RDF_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic [11:0] out_cnt;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || block_start_o) begin
            out_cnt <= {11'h0, block_start_o};
        end else if (word_valid_o) begin
            out_cnt <= out_cnt + 12'h1;
        end
    end

    block_length_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        block_start_o && out_cnt != 12'h0 |-> out_cnt == 12'(BLOCK_WORDS))
        else $error("block not 2048 words");
    sync_word_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        block_start_o |-> word_o == SYNC_LOW)
        else $error("block does not open with sync");
    sync_high_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        block_start_o ##1 word_valid_o |-> word_o[23:19] == SYNC_HIGH)
        else $error("sync high bits wrong");
    blk_count_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || session_start)
        block_end |=> block_sequence_counter == $past(block_sequence_counter) + 24'h1)
        else $error("block counter did not step");
    word6_spare_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        block_start_o ##6 word_valid_o |-> word_o[18:17] == 2'b00)
        else $error("session word 6 spare nonzero");
    word7_spare_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        block_start_o ##7 word_valid_o |-> word_o[15:6] == 10'h0 && word_o[5:0] == format_revision)
        else $error("session word 7 layout wrong");
    fill_ones_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        state == RDF_FILL |=> word_valid_o && word_o == FILL_WORD)
        else $error("fill word not all ones");
    word_count_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        state == RDF_CH_HDR && widx == 3'h0 |=> word_o[15:5] == cur_wc && cur_wc <= MAX_WORD_COUNT)
        else $error("word count field wrong");
    date_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !sec_tick && !session_start |=> $stable(date_bcd_field))
        else $error("date changed off the second tick");

    block_seen_c: cover property (@(posedge sys_clk_i) disable iff (reset_i) block_end);
    fill_seen_c: cover property (@(posedge sys_clk_i) disable iff (reset_i) state == RDF_FILL ##1 block_end);
    split_seen_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        take && fill + 6'(cur_w) > 6'(WORD_BITS));
    overflow_c: cover property (@(posedge sys_clk_i) disable iff (reset_i) state == RDF_CH_DATA && last_word);
endmodule

//--- testbench/rdf_src.sv
// sample source feeding the framer, stalling at random
`timescale 1ns/1ps
module rdf_src (
    input  wire logic        clk_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic      [23:0] sample_o
);
    initial begin
        valid_o = 1'b0;
        sample_o = 24'h000000;
    end
    // an offered sample holds until taken; otherwise data changes every cycle so stale values never match
    always @(posedge clk_i) begin
        if (!(valid_o && !ready_i)) begin
            valid_o <= ($urandom % 4) != 0;
            sample_o <= 24'($urandom);
        end
    end
endmodule

//--- testbench/rdf_framer_tb.sv
// self-checking testbench of the recorder data block framer
`timescale 1ns/1ps
module rdf_framer_tb;
    import rdf_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, go = 0, sv, rdy, vld, bs;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [23:0] smp, w, e[8], q[$];
    logic [3:0]  sch;
    logic [7:0]  u;
    logic [23:0] sq[$];
    logic [3:0]  cq[$];
    int          sl[2] = '{3, 9}, cd[2] = '{7, 8}, nn[2] = '{5, 3};
    int          n_fail = 0, comparisons = 0;
    rdf_framer #(.NUM_CH(16), .TICK_CYCLES(20)) u_rdf_framer (.sys_clk_i(clk), .reset_i(rst), .addr_i(addr),
        .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .block_go_i(go), .sample_valid_i(sv),
        .sample_i(smp), .sample_ready_o(rdy), .sample_chan_o(sch), .word_o(w), .word_valid_o(vld),
        .block_start_o(bs));
    rdf_src u_rdf_src (.clk_i(clk), .ready_i(rdy), .valid_o(sv), .sample_o(smp));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wreg(logic [7:0] a, logic [31:0] d);
        @(posedge clk) begin addr <= a; wd <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(logic [7:0] a, logic [31:0] x, string n);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 chk(n, x, rdat);
    endtask
    // model of channel header word 0 from slot, width code and sample count
    function automatic logic [23:0] hdr(int s, int c, int n);
        int wb = (c < 8) ? c + 1 : 2 * c - 6;
        int r = (n * wb) % 24;
        int p = (r < wb) ? 0 : (24 - r + wb - 1) / wb;
        return {4'(s), 4'(c), 11'(n * wb / 24), 5'(p)};
    endfunction
    // block start must coincide with the first collected word
    always @(posedge clk) begin
        if (vld && bs) chk("start", 0, 32'(q.size()));
        if (vld) q.push_back(w);
    end
    // every taken sample, with the channel the design claims to be packing
    always @(posedge clk) begin
        if (rdy && sv) begin
            sq.push_back(smp);
            cq.push_back(sch);
        end
    end
    // model of one packet: samples msb first in taken order, the first rem bits lead as the partial word
    task automatic chk_pkt(int k, inout int at);
        int wb = (cd[k] < 8) ? cd[k] + 1 : 2 * cd[k] - 6;
        int nw = nn[k] * wb / 24;
        logic [23:0] x;
        bit bq[$];
        chk("hdr", hdr(sl[k], cd[k], nn[k]), q[at]);
        for (int i = 0; i < nn[k]; i++) begin
            x = sq.pop_front();
            chk("chan", k, cq.pop_front());
            for (int b = wb - 1; b >= 0; b--) bq.push_back(x[b]);
        end
        for (int j = 0; j <= nw; j++) begin
            x = 24'h0;
            for (int b = 0; b < ((j == 0) ? nn[k] * wb % 24 : 24); b++) x[23 - b] = bq.pop_front();
            chk("data", x, q[at + 4 + j]);
        end
        at += 5 + nw;
    endtask
    task automatic run_block(string t);
        int at = 8;
        q.delete();
        sq.delete();
        cq.delete();
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        for (int i = 0; i < 8000 && q.size() < 2048; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk("length", 2048, 32'(q.size()));
        for (int i = 0; i < 8; i++) chk("session", e[i], q[i]);
        for (int k = 0; k < 2; k++) chk_pkt(k, at);
        for (int i = at; i < 2048; i++) chk("fill", FILL_WORD, q[i]);
        $display("test %s done", t);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        test_done();
    end
    initial begin
        void'($urandom(71851));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rreg(REVISION_ADDR, 32'(REVISION_RESET), "revision");
        rreg(8'h3c, 32'h0, "unmapped");
        u = 8'($urandom);
        wreg(MCLK_ADDR, 32'h1f40);
        wreg(DIVISOR_ADDR, 32'h400);
        wreg(CHCOUNT_ADDR, 32'h1);
        wreg(START_SEC_ADDR, 32'h1517f);
        wreg(USER_ADDR, {24'h0, u});
        wreg(DATE_ADDR, 32'h240315);
        wreg(TIME_ADDR, 32'h123456);
        wreg(CHCFG_BASE, {4'(sl[0]), 4'(cd[0]), 8'h0, 16'(nn[0])});
        wreg(CHCFG_BASE + 8'h04, {4'(sl[1]), 4'(cd[1]), 8'h0, 16'(nn[1])});
        wreg(CTRL_ADDR, 32'h7);
        e = '{SYNC_LOW, {SYNC_HIGH, 19'h1f40}, 24'h0, 24'h240315, 24'h123456, 24'h400, {5'h11, 2'h0, 17'h1517f},
              {u, 10'h0, REVISION_RESET}};
        run_block("first");
        rreg(BLKCNT_ADDR, 32'h1, "blkcnt");
        u = 8'($urandom);
        wreg(USER_ADDR, {24'h0, u});
        wreg(DATE_ADDR, 32'h240316);
        // random width code and count on the first channel reach other splits and partial words
        cd[0] = $urandom % 16;
        nn[0] = 1 + $urandom % 40;
        wreg(CHCFG_BASE, {4'(sl[0]), 4'(cd[0]), 8'h0, 16'(nn[0])});
        repeat (30) @(posedge clk);
        e[2] = 24'h1;
        e[3] = 24'h240316;
        e[7] = {u, 10'h0, REVISION_RESET};
        run_block("second");
        test_done();
    end
endmodule
